// file: logic/address_event_trigger_unit.sv
/*
 * address event trigger unit: watches core bus cycles, matches data and
 * program addresses against ranges, drives trigger pins and trace gating.
 * assumes core bus signals come from logic on mclk; wishbone master is
 * classic single cycle on the same clock.
 */
`timescale 1ns/1ps

// How it works
// - two-output variant gives two trigger pins, one-cycle pulse per event
// - begin/end/hit variant: single pin pulses or changes level per waveform mode bit
// - data access inside a configured data range raises an event
// - program access or fetch inside a program range raises an event
// - two-output variant: each event feeds at most one chosen pin, none for type codes 2 and 3
// - begin/end/hit events steer either trace recording or trigger pin
// - begin event makes its condition active from the matching access
// - end event makes its condition inactive at the matching access
// - hit event asserts its condition for the matching cycle only
// - force variant: force-high sets pin one, force-low sets pin zero
// - each event has its own enable, disabled events do nothing
// - one global enable gates every event together
// - range is begin to end base plus offset, any address inside matches
module address_event_trigger_unit
	import trig_unit_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              arst_n,
	// wishbone slave
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [WB_AW-1:0]  wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	// emulated core bus
	input  wire logic [ADDR_W-1:0] coreAddr,
	input  wire logic              coreDataAccess,
	input  wire logic              coreProgAccess,
	// outputs
	output logic                   trig_out_a,
	output logic                   trig_out_b,
	output logic                   single_trigger_output,
	output logic                   traceRecord
);

	// ==========================================================
	// register file
	logic [3:0]        ctrl_q;
	logic [CFG_W-1:0]  cfg_q     [NUM_EV];
	logic [ADDR_W-1:0] begin_q   [NUM_EV];
	logic [ADDR_W-1:0] endBase_q [NUM_EV];
	logic [ADDR_W-1:0] endOfs_q  [NUM_EV];
	logic              ack_q;
	logic [31:0]       rdat_q;

	logic              req;
	logic              wrStb;
	logic [1:0]        evWord;
	logic [WB_AW-1:0]  evOfs;
	logic              evSel     [NUM_EV];

	// ==========================================================
	// event logic signals
	logic [NUM_EV-1:0] rawHit;
	logic [NUM_EV-1:0] live;
	logic [NUM_EV-1:0] tyA, tyB, tyEnd, tyHit;
	logic [NUM_EV-1:0] toTrace;
	logic [1:0]        variant;
	logic              globalEn;
	logic              waveLevel;

	logic              trigLvl_q, trigLvl_d;
	logic              traceLvl_q, traceLvl_d;
	logic              trigA_q, trigB_q, single_q, trace_q;
	logic              single_d, trace_d;
	logic [NUM_EV-1:0] match_q;

	logic setT, clrT, hitT, anyT;
	logic setR, clrR, hitR;

	assign globalEn  = ctrl_q[CTRL_GEN];
	assign variant   = ctrl_q[CTRL_VAR_HI:CTRL_VAR_LO];
	assign waveLevel = ctrl_q[CTRL_WAVE];

	// a new request only when no ack is pending, so each access acks once
	assign req    = wb_cyc_i && wb_stb_i && !ack_q;
	assign wrStb  = req && wb_we_i && wb_sel_i[0];
	assign evOfs  = wb_adr_i - OFS_EV_BASE;
	assign evWord = wb_adr_i[3:2];

	// ==========================================================
	// per-event decode, comparator and type flags
	genvar gi;
	generate
		for (gi = 0; gi < NUM_EV; gi++) begin : g_ev
			logic access;

			assign evSel[gi] = (wb_adr_i >= OFS_EV_BASE)
				&& (evOfs[WB_AW-1:4] == (WB_AW-4)'(gi));

			// data ranges watch data cycles, program ranges fetch and reads
			assign access = cfg_q[gi][CFG_PROG] ? coreProgAccess
				: coreDataAccess;

			range_match u_match (
				.addr       (coreAddr),
				.access     (access),
				.rangeBegin (begin_q[gi]),
				.endBase    (endBase_q[gi]),
				.endOfs     (endOfs_q[gi]),
				.hit        (rawHit[gi])
			);

			// own enable and global enable both needed
			assign live[gi] = rawHit[gi] && cfg_q[gi][CFG_EN] && globalEn;

			assign tyA[gi]     = cfg_q[gi][CFG_TYPE_HI:CFG_TYPE_LO] == TY_OUT_A;
			assign tyB[gi]     = cfg_q[gi][CFG_TYPE_HI:CFG_TYPE_LO] == TY_OUT_B;
			assign tyEnd[gi]   = cfg_q[gi][CFG_TYPE_HI:CFG_TYPE_LO] == TY_END;
			assign tyHit[gi]   = cfg_q[gi][CFG_TYPE_HI:CFG_TYPE_LO] == TY_HIT;
			// force events always act on the pin, never on trace
			assign toTrace[gi] = cfg_q[gi][CFG_TRACE] && (variant == VAR_BEH);

			// event register writes, low byte lanes only matter
			always_ff @(posedge mclk or negedge arst_n) begin
				if (!arst_n) begin
					cfg_q[gi]     <= CFG_RST;
					begin_q[gi]   <= '0;
					endBase_q[gi] <= '0;
					endOfs_q[gi]  <= '0;
				end else if (req && wb_we_i && evSel[gi]) begin
					unique case (evWord)
						EVW_CFG: begin
							if (wb_sel_i[0])
								cfg_q[gi] <= wb_dat_i[CFG_W-1:0];
						end
						EVW_BEGIN: begin
							if (wb_sel_i[0])
								begin_q[gi][7:0] <= wb_dat_i[7:0];
							if (wb_sel_i[1])
								begin_q[gi][15:8] <= wb_dat_i[15:8];
						end
						EVW_ENDBASE: begin
							if (wb_sel_i[0])
								endBase_q[gi][7:0] <= wb_dat_i[7:0];
							if (wb_sel_i[1])
								endBase_q[gi][15:8] <= wb_dat_i[15:8];
						end
						EVW_ENDOFS: begin
							if (wb_sel_i[0])
								endOfs_q[gi][7:0] <= wb_dat_i[7:0];
							if (wb_sel_i[1])
								endOfs_q[gi][15:8] <= wb_dat_i[15:8];
						end
					endcase
				end
			end
		end
	endgenerate

	// ==========================================================
	// control register
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			ctrl_q <= CTRL_RST;
		else if (wrStb && wb_adr_i == OFS_CTRL)
			ctrl_q <= wb_dat_i[3:0];
	end

	// ==========================================================
	// bus answer: ack one cycle after the strobe, dropped next cycle
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			ack_q <= 1'b0;
		else
			ack_q <= req;
	end

	// read data, unmapped offsets read zero and writes there are ignored
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rdat_q <= '0;
		end else if (req) begin
			rdat_q <= '0;
			if (wb_adr_i == OFS_CTRL)
				rdat_q[3:0] <= ctrl_q;
			else if (wb_adr_i == OFS_STATUS)
				rdat_q[ST_MATCH+NUM_EV-1:0] <=
					{match_q, trace_q, single_q, trigB_q, trigA_q};
			else begin
				for (int i = 0; i < NUM_EV; i++) begin
					if (evSel[i]) begin
						unique case (evWord)
							EVW_CFG:     rdat_q[CFG_W-1:0]  <= cfg_q[i];
							EVW_BEGIN:   rdat_q[ADDR_W-1:0] <= begin_q[i];
							EVW_ENDBASE: rdat_q[ADDR_W-1:0] <= endBase_q[i];
							EVW_ENDOFS:  rdat_q[ADDR_W-1:0] <= endOfs_q[i];
						endcase
					end
				end
			end
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	// ==========================================================
	// condition next-state; begin and end share type codes with force
	always_comb begin
		setT = |(live & ~toTrace & ~tyEnd & ~tyHit & ~tyB);
		clrT = |(live & ~toTrace & tyEnd);
		hitT = |(live & ~toTrace & tyHit);
		anyT = |(live & ~toTrace);
		setR = |(live & toTrace & ~tyEnd & ~tyHit);
		clrR = |(live & toTrace & tyEnd);
		hitR = |(live & toTrace & tyHit);
		trigLvl_d  = trigLvl_q;
		traceLvl_d = traceLvl_q;
		// a set seen together with a clear wins, so no begin is lost
		unique case (variant)
			VAR_BEH: begin
				if (setT)
					trigLvl_d = 1'b1;
				else if (clrT)
					trigLvl_d = 1'b0;
				if (setR)
					traceLvl_d = 1'b1;
				else if (clrR)
					traceLvl_d = 1'b0;
			end
			VAR_FORCE: begin
				// force-high uses the begin code, force-low the end code
				if (|(live & tyA))
					trigLvl_d = 1'b1;
				else if (|(live & tyB))
					trigLvl_d = 1'b0;
			end
			default: begin
				trigLvl_d  = 1'b0;
				traceLvl_d = 1'b0;
			end
		endcase
	end

	// single pin: pulse mode flashes on any trigger event
	always_comb begin
		single_d = 1'b0;
		trace_d  = 1'b0;
		if (variant == VAR_FORCE)
			single_d = trigLvl_d;
		else if (variant == VAR_BEH) begin
			single_d = waveLevel ? (trigLvl_d | hitT) : anyT;
			trace_d  = traceLvl_d | hitR;
		end
	end

	// ==========================================================
	// held conditions
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			trigLvl_q  <= 1'b0;
			traceLvl_q <= 1'b0;
		end else begin
			trigLvl_q  <= trigLvl_d;
			traceLvl_q <= traceLvl_d;
		end
	end

	// registered pins, one cycle after the matching bus cycle
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			trigA_q  <= 1'b0;
			trigB_q  <= 1'b0;
			single_q <= 1'b0;
			trace_q  <= 1'b0;
			match_q  <= '0;
		end else begin
			// each event reaches only the pin its type names
			trigA_q  <= (variant == VAR_TWO) && |(live & tyA);
			trigB_q  <= (variant == VAR_TWO) && |(live & tyB);
			single_q <= single_d;
			trace_q  <= trace_d;
			match_q  <= live;
		end
	end

	assign trig_out_a            = trigA_q;
	assign trig_out_b            = trigB_q;
	assign single_trigger_output = single_q;
	assign traceRecord           = trace_q;

	// ==========================================================
	// checks
	a_pulse_a_cause: assert property (@(posedge mclk) disable iff (!arst_n)
		trig_out_a |-> $past(variant == VAR_TWO && |(live & tyA)))
		else $error("pin a pulsed without an event");

	a_pulse_one_cycle: assert property (@(posedge mclk) disable iff (!arst_n)
		(variant == VAR_TWO && |(live & tyA)) |=> trig_out_a)
		else $error("pin a missed its event");

	a_pins_exclusive: assert property (@(posedge mclk) disable iff (!arst_n)
		(variant == VAR_TWO && |(live & tyB) && !(|(live & tyA)))
		|=> !trig_out_a && trig_out_b)
		else $error("event reached the wrong pin");

	a_pulse_b_cause: assert property (@(posedge mclk) disable iff (!arst_n)
		trig_out_b |-> $past(variant == VAR_TWO && |(live & tyB)))
		else $error("pin b pulsed without an event");

	a_trace_begin: assert property (@(posedge mclk) disable iff (!arst_n)
		(variant == VAR_BEH && setR) |=> traceRecord)
		else $error("begin event did not start trace");

	a_trace_hit: assert property (@(posedge mclk) disable iff (!arst_n)
		(variant == VAR_BEH && hitR && !setR && !traceLvl_q)
		##1 (variant == VAR_BEH && live == '0) |-> traceRecord ##1 !traceRecord)
		else $error("hit event held trace past its cycle");

	a_global_gate: assert property (@(posedge mclk) disable iff (!arst_n)
		!globalEn |=> !trig_out_a && !trig_out_b && !$past(|live))
		else $error("event passed while globally disabled");

	a_event_enable: assert property (@(posedge mclk) disable iff (!arst_n)
		(rawHit == 4'h1 && !cfg_q[0][CFG_EN]) |-> !live[0])
		else $error("disabled event was live");

	a_end_clears: assert property (@(posedge mclk) disable iff (!arst_n)
		(variant == VAR_BEH && clrT && !setT && !hitT && waveLevel)
		##1 (variant == VAR_BEH && live == '0) |=> !single_trigger_output)
		else $error("end event left level high");

	a_begin_holds: assert property (@(posedge mclk) disable iff (!arst_n)
		(variant == VAR_BEH && setT && waveLevel) |=> single_trigger_output)
		else $error("begin event did not raise level");

	a_force_low: assert property (@(posedge mclk) disable iff (!arst_n)
		(variant == VAR_FORCE && |(live & tyB) && !(|(live & tyA)))
		|=> !single_trigger_output ##1 (!single_trigger_output || $past(|(live & tyA))))
		else $error("force low did not drive zero");

	a_bus_ack_once: assert property (@(posedge mclk) disable iff (!arst_n)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");

endmodule // address_event_trigger_unit

// file: logic/trig_unit_pkg.sv
/*
 * constants for the address event trigger unit: register map, field
 * positions, variant and event type codes.
 * assumes a 32-bit classic wishbone slave port and a 16-bit core address.
 */
package trig_unit_pkg;

	// ==========================================================
	// sizes
	localparam int ADDR_W  = 16;
	localparam int NUM_EV  = 4;
	localparam int WB_AW   = 8;

	// ==========================================================
	// register byte offsets
	localparam logic [WB_AW-1:0] OFS_CTRL     = 8'h00;
	localparam logic [WB_AW-1:0] OFS_STATUS   = 8'h04;
	localparam logic [WB_AW-1:0] OFS_EV_BASE  = 8'h10;
	localparam logic [WB_AW-1:0] OFS_EV_SPAN  = 8'h10;
	// word index inside one event block
	localparam logic [1:0]       EVW_CFG      = 2'h0;
	localparam logic [1:0]       EVW_BEGIN    = 2'h1;
	localparam logic [1:0]       EVW_ENDBASE  = 2'h2;
	localparam logic [1:0]       EVW_ENDOFS   = 2'h3;

	// ==========================================================
	// control register fields
	localparam int CTRL_GEN    = 0;
	localparam int CTRL_VAR_LO = 1;
	localparam int CTRL_VAR_HI = 2;
	localparam int CTRL_WAVE   = 3;
	localparam logic [3:0] CTRL_RST = 4'h0;

	// variant codes
	localparam logic [1:0] VAR_TWO   = 2'h0;
	localparam logic [1:0] VAR_BEH   = 2'h1;
	localparam logic [1:0] VAR_FORCE = 2'h2;

	// ==========================================================
	// event config fields
	localparam int CFG_EN      = 0;
	localparam int CFG_PROG    = 1;
	localparam int CFG_TYPE_LO = 2;
	localparam int CFG_TYPE_HI = 3;
	localparam int CFG_TRACE   = 4;
	localparam int CFG_W       = 5;
	localparam logic [CFG_W-1:0] CFG_RST = 5'h00;

	// event type codes, meaning depends on variant
	localparam logic [1:0] TY_OUT_A    = 2'h0;
	localparam logic [1:0] TY_OUT_B    = 2'h1;
	localparam logic [1:0] TY_BEGIN    = 2'h0;
	localparam logic [1:0] TY_END      = 2'h1;
	localparam logic [1:0] TY_HIT      = 2'h2;
	localparam logic [1:0] TY_FORCE_HI = 2'h0;
	localparam logic [1:0] TY_FORCE_LO = 2'h1;

	// status register fields
	localparam int ST_TRIG_A = 0;
	localparam int ST_TRIG_B = 1;
	localparam int ST_SINGLE = 2;
	localparam int ST_TRACE  = 3;
	localparam int ST_MATCH  = 4;

endpackage

// file: logic/range_match.sv
/*
 * one address range comparator.
 * assumes begin, end base and offset are held stable by the register file.
 */
`timescale 1ns/1ps
module range_match
	import trig_unit_pkg::*;
(
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic              access,
	input  wire logic [ADDR_W-1:0] rangeBegin,
	input  wire logic [ADDR_W-1:0] endBase,
	input  wire logic [ADDR_W-1:0] endOfs,
	output logic                   hit
);

	// ==========================================================
	// inclusive bounds
	// one extra bit so base plus offset cannot wrap to a low end
	logic [ADDR_W:0] rangeEnd;

	// end address is base plus offset
	assign rangeEnd = {1'b0, endBase} + {1'b0, endOfs};

	// both bounds inclusive, checked on every core cycle
	assign hit = access
		&& ({1'b0, addr} >= {1'b0, rangeBegin})
		&& ({1'b0, addr} <= rangeEnd);

endmodule // range_match

// file: bench/core_bus_model.sv
/*
 * core bus model: stands for the emulated core, one access per call.
 * assumes the unit samples the core bus on every rising mclk edge.
 */
`timescale 1ns/1ps
module core_bus_model
	import trig_unit_pkg::*;
(
	input  wire logic              mclk,
	output logic      [ADDR_W-1:0] coreAddr,
	output logic                   coreDataAccess,
	output logic                   coreProgAccess
);
	// ====================
	// idle bus at time zero
	initial begin
		coreAddr       = '0;
		coreDataAccess = 1'b0;
		coreProgAccess = 1'b0;
	end

	// one-cycle access; the address flips when idle so stale matches show
	task automatic access(input logic [ADDR_W-1:0] a, input logic prog);
		@(posedge mclk);
		coreAddr       <= a;
		coreDataAccess <= !prog;
		coreProgAccess <= prog;
		@(posedge mclk);
		coreAddr       <= ~a;
		coreDataAccess <= 1'b0;
		coreProgAccess <= 1'b0;
	endtask
endmodule // core_bus_model

// file: bench/address_event_trigger_unit_tb.sv
/*
 * bench of the address event trigger unit: wishbone tasks, scenarios
 * and the verdict.
 * assumes the core bus model stands in for the emulated core.
 */
`timescale 1ns/1ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin err_count++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end
module address_event_trigger_unit_tb
	import trig_unit_pkg::*;
;
	// ====================
	// signals
	logic              mclk, arst_n, wbCyc, wbStb, wbWe, wbAck;
	logic [WB_AW-1:0]  wbAdr;
	logic [3:0]        wbSel;
	logic [31:0]       wbWdat, wbRdat, rd;
	logic [ADDR_W-1:0] coreAddr;
	logic              dataAcc, progAcc, trigA, trigB, trigSingle, traceRec;
	logic [3:0]        outs;
	int                err_count, num_checks;

	assign outs = {trigA, trigB, trigSingle, traceRec};

	// clock and time-zero inputs
	initial begin
		mclk = 1'b0;
		arst_n = 1'b0;
		{wbCyc, wbStb, wbWe, wbAdr, wbSel, wbWdat} = '0;
		err_count = 0;
		num_checks = 0;
	end
	always #10 mclk = ~mclk;

	address_event_trigger_unit address_event_trigger_unit_i (
		.mclk(mclk), .arst_n(arst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
		.wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbWdat),
		.wb_dat_o(wbRdat), .wb_ack_o(wbAck), .coreAddr(coreAddr),
		.coreDataAccess(dataAcc), .coreProgAccess(progAcc), .trig_out_a(trigA),
		.trig_out_b(trigB), .single_trigger_output(trigSingle),
		.traceRecord(traceRec));

	core_bus_model core_bus_model_i (.mclk(mclk), .coreAddr(coreAddr),
		.coreDataAccess(dataAcc), .coreProgAccess(progAcc));

	// ====================
	// bus tasks; the answer is awaited, never counted on
	task automatic wbCycle(input logic we, input logic [WB_AW-1:0] adr,
		input logic [31:0] dat);
		int n;
		n = 0;
		@(posedge mclk);
		{wbCyc, wbStb, wbWe, wbAdr, wbSel, wbWdat} <= {2'b11, we, adr, 4'h3, dat};
		do begin
			@(posedge mclk);
			n++;
		end while (wbAck !== 1'b1 && n < 50);
		// a slave that never answers is a failure, not a silent skip
		if (wbAck !== 1'b1) begin
			err_count++;
			$display("[FAIL] t=%0t ack timeout got=%h exp=%h", $time, wbAck, 1'b1);
		end
		rd = wbRdat;
		{wbCyc, wbStb, wbWe} <= 3'b000;
	endtask

	task automatic setEv(input logic [1:0] i, input logic [4:0] cfg,
		input logic [15:0] beg, input logic [15:0] eb, input logic [15:0] eo);
		logic [WB_AW-1:0] b;
		b = OFS_EV_BASE + {2'b00, i, 4'h0};
		wbCycle(1'b1, b + {EVW_CFG, 2'b00}, {27'h0, cfg});
		wbCycle(1'b1, b + {EVW_BEGIN, 2'b00}, {16'h0, beg});
		wbCycle(1'b1, b + {EVW_ENDBASE, 2'b00}, {16'h0, eb});
		wbCycle(1'b1, b + {EVW_ENDOFS, 2'b00}, {16'h0, eo});
	endtask

	// one access, then outputs in the answer cycle and the one after
	task automatic hit(input logic [15:0] a, input logic p, input logic [3:0] e1,
		input logic [3:0] e2);
		core_bus_model_i.access(a, p);
		#1 `CHK(outs, e1)
		@(posedge mclk);
		#1 `CHK(outs, e2)
	endtask

	// ====================
	// scenarios
	task automatic testRegs();
		wbCycle(1'b0, OFS_CTRL, 32'h0);
		`CHK(rd, 32'h0)
		wbCycle(1'b1, 8'h08, 32'hffff);
		wbCycle(1'b0, 8'h08, 32'h0);
		`CHK(rd, 32'h0)
		wbCycle(1'b1, 8'h44, 32'ha5c3);
		wbCycle(1'b0, 8'h44, 32'h0);
		`CHK(rd, 32'h0000a5c3)
	endtask

	task automatic testTwoOut();
		wbCycle(1'b1, OFS_CTRL, 32'h01);
		setEv(2'd0, 5'b00001, 16'h0100, 16'h0108, 16'h0008);
		setEv(2'd1, 5'b00111, 16'h0400, 16'h0400, 16'h0000);
		hit(16'h0100, 1'b0, 4'b1000, 4'b0000);
		hit(16'h0110, 1'b0, 4'b1000, 4'b0000);
		hit(16'h0111, 1'b0, 4'b0000, 4'b0000);
		hit(16'h00ff, 1'b0, 4'b0000, 4'b0000);
		hit(16'h0400, 1'b1, 4'b0100, 4'b0000);
		hit(16'h0400, 1'b0, 4'b0000, 4'b0000);
		hit(16'h0104, 1'b1, 4'b0000, 4'b0000);
	endtask

	task automatic testEnables();
		wbCycle(1'b1, OFS_EV_BASE, 32'h00);
		hit(16'h0100, 1'b0, 4'b0000, 4'b0000);
		wbCycle(1'b1, OFS_EV_BASE, 32'h01);
		hit(16'h0100, 1'b0, 4'b1000, 4'b0000);
		wbCycle(1'b1, OFS_CTRL, 32'h00);
		hit(16'h0100, 1'b0, 4'b0000, 4'b0000);
		wbCycle(1'b1, OFS_CTRL, 32'h01);
		hit(16'h0100, 1'b0, 4'b1000, 4'b0000);
	endtask

	// force first, so no begin/end level is left over from earlier runs
	task automatic testForce();
		wbCycle(1'b1, OFS_CTRL, 32'h05);
		setEv(2'd0, 5'b00001, 16'h0200, 16'h0200, 16'h0000);
		setEv(2'd1, 5'b00101, 16'h0300, 16'h0300, 16'h0000);
		hit(16'h0200, 1'b0, 4'b0010, 4'b0010);
		hit(16'h0300, 1'b0, 4'b0000, 4'b0000);
	endtask

	task automatic testBeh();
		wbCycle(1'b1, OFS_CTRL, 32'h0b);
		setEv(2'd2, 5'b11001, 16'h0500, 16'h0500, 16'h0000);
		hit(16'h0200, 1'b0, 4'b0010, 4'b0010);
		hit(16'h0250, 1'b0, 4'b0010, 4'b0010);
		hit(16'h0300, 1'b0, 4'b0000, 4'b0000);
		hit(16'h0500, 1'b0, 4'b0001, 4'b0000);
		wbCycle(1'b1, OFS_CTRL, 32'h03);
		hit(16'h0200, 1'b0, 4'b0010, 4'b0000);
	endtask

	// trace steered by begin and end events, trace bit seen in status too
	task automatic testTrace();
		wbCycle(1'b1, OFS_EV_BASE, 32'h11);
		wbCycle(1'b1, OFS_EV_BASE + OFS_EV_SPAN, 32'h15);
		hit(16'h0200, 1'b0, 4'b0001, 4'b0001);
		wbCycle(1'b0, OFS_STATUS, 32'h0);
		`CHK(rd, 32'h00000008)
		hit(16'h0300, 1'b0, 4'b0000, 4'b0000);
	endtask

	// ====================
	// verdict and run order
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge mclk);
		arst_n <= 1'b1;
		testRegs();
		testTwoOut();
		testEnables();
		testForce();
		testBeh();
		testTrace();
		print_verdict();
	end

	// watchdog well beyond the under two hundred cycles the scenarios take
	initial begin
		#200000;
		err_count++;
		print_verdict();
	end
endmodule // address_event_trigger_unit_tb
